// File: hdl/idf_pkg.sv
package idf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  OFF_CTRL = 8'h00;  // Enable and mode bits
    localparam logic [7:0]  OFF_DATA = 8'h10;  // Byte buffer
    localparam logic [7:0]  OFF_STAT = 8'h14;  // Status flags
    localparam logic [7:0]  OFF_ISTS = 8'h20;  // Interrupt status, write one to clear
    localparam logic [7:0]  OFF_IMSK = 8'h24;  // Interrupt mask

    // Control bits
    localparam int C_EN    = 0;  // Peripheral enable
    localparam int C_HOST  = 1;  // SMBus host mode
    localparam int C_ACK   = 2;  // Acknowledge enable
    localparam int C_NOSTR = 3;  // Stretch disable
    localparam int CTRL_W  = 4;

    // Status bit positions
    localparam int B_ALERT = 15;
    localparam int B_TOUT  = 14;
    localparam int B_PEC   = 12;
    localparam int B_OVR   = 11;
    localparam int B_TXE   = 7;
    localparam int DATA_W  = 8;

    // Error flag index, shared by status, interrupt status and mask
    localparam int I_ALERT = 0;
    localparam int I_TOUT  = 1;
    localparam int I_PEC   = 2;
    localparam int I_OVR   = 3;
    localparam int IRQ_W   = 4;
    localparam int ERR_POS [IRQ_W] = '{B_ALERT, B_TOUT, B_PEC, B_OVR};

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RST  = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_MHZ  = 250;
    localparam int T_LOW_MS  = 25;  // SCL held low
    localparam int T_MEXT_MS = 10;  // Master cumulative extension
    localparam int T_SEXT_MS = 25;  // Slave cumulative extension
    localparam int CYC_PER_MS = MCLK_MHZ * 1000;
    localparam int CNT_W     = 23;
    localparam logic [CNT_W-1:0] TLOW_CYC  = CNT_W'(T_LOW_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] TMEXT_CYC = CNT_W'(T_MEXT_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] TSEXT_CYC = CNT_W'(T_SEXT_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] CNT_ONE   = 23'h000001;

    // ------------------------------------------------------------
    // Protocol engine carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              rxDone;       // Byte completed on the bus, pulse
        logic [DATA_W-1:0] rxByte;       // Completed byte
        logic              rxIsAddr;     // Completed byte was the matched address
        logic              arbLostAck;   // Arbitration lost during the acknowledge pulse
        logic              pecMismatch;  // Received check code mismatch, pulse
        logic              txDue;        // Next byte to send is taken, pulse
        logic              alertRespAddr;// Alert response address received, pulse
        logic              slaveMode;    // Device acts as slave
        logic              transmitting; // Device is the transmitter
        logic              ownStretch;   // Device itself holds SCL low
        logic              msgActive;    // Between start and stop
    } idf_eng_s;

    typedef struct packed {
        logic [DATA_W-1:0] txByte;       // Byte to send next
        logic              forceNack;    // Answer not-acknowledge, pulse
        logic              genStop;      // Generate a stop, pulse
        logic              resetComm;    // Abandon transfer and release lines, pulse
    } idf_cmd_s;

endpackage : idf_pkg

// File: hdl/idf_data_flags.sv
`timescale 1ns/100ps
module idf_data_flags #(
    parameter logic [idf_pkg::CNT_W-1:0] SCL_LOW_CYC = idf_pkg::TLOW_CYC,  // SCL low timeout
    parameter logic [idf_pkg::CNT_W-1:0] MEXT_CYC    = idf_pkg::TMEXT_CYC, // Master extension
    parameter logic [idf_pkg::CNT_W-1:0] SEXT_CYC    = idf_pkg::TSEXT_CYC  // Slave extension
) (
    input  wire logic                        mclk,       // 250 MHz clock
    input  wire logic                        rst_n,      // Synchronous reset, active low
    input  wire logic                        psel,       // APB select
    input  wire logic                        penable,    // APB enable
    input  wire logic                        pwrite,     // APB direction
    input  wire logic [idf_pkg::ADDR_W-1:0]  paddr,      // APB byte address
    input  wire logic [31:0]                 pwdata,     // APB write data
    output logic                             pready,     // APB ready
    output logic [31:0]                      prdata,     // APB read data
    output logic                             pslverr,    // Unmapped address
    input  wire idf_pkg::idf_eng_s           eng,        // Protocol engine events
    output idf_pkg::idf_cmd_s                cmd,        // Commands to the engine
    input  wire logic                        sclIn,      // SCL line level
    input  wire logic                        alert_flag_n, // SMBus alert pin, active low
    output logic                             irq         // Interrupt, active high level
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sclMeta, sclSync, alertMeta, alertSync, alertPrev;

    // Two flops on both pins plus a third on alert; SCL reads the second, the alert edge uses the second and third
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sclMeta   <= 1'b1;
            sclSync   <= 1'b1;
            alertMeta <= 1'b1;
            alertSync <= 1'b1;
            alertPrev <= 1'b1;
        end else begin
            sclMeta   <= sclIn;
            sclSync   <= sclMeta;
            alertMeta <= alert_flag_n;
            alertSync <= alertMeta;
            alertPrev <= alertSync;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [idf_pkg::CTRL_W-1:0] ctrl;
    logic [idf_pkg::DATA_W-1:0] dataByte;
    logic [idf_pkg::IRQ_W-1:0]  errFlag, irqSts, irqMask, ev;
    logic                       txEmptyFlag, txPending, rxUnread;
    logic [31:0]                rdWord, statusWord;
    logic                       acc, wr, hitCtrl, hitData, hitStat, hitIsts, hitImsk, mapped;
    logic                       wrData, wrStat, dataRead, en, host, noStr;

    // Transfer completes on the access cycle with pready high
    assign acc      = psel & penable & pready;
    assign wr       = acc & pwrite;
    assign hitCtrl  = (paddr == idf_pkg::OFF_CTRL);
    assign hitData  = (paddr == idf_pkg::OFF_DATA);
    assign hitStat  = (paddr == idf_pkg::OFF_STAT);
    assign hitIsts  = (paddr == idf_pkg::OFF_ISTS);
    assign hitImsk  = (paddr == idf_pkg::OFF_IMSK);
    assign mapped   = hitCtrl | hitData | hitStat | hitIsts | hitImsk;
    assign wrData   = wr & hitData;
    assign wrStat   = wr & hitStat;
    assign dataRead = acc & ~pwrite & hitData;
    assign en       = ctrl[idf_pkg::C_EN];
    assign host     = ctrl[idf_pkg::C_HOST];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic [idf_pkg::CNT_W-1:0] sclLowCnt, extAcc, extLimit;
    logic                      sclLowHit, extOn, extHit, rxData, evOver, evUnder, store, evTout;

    // SCL low counter saturates at the limit so the event fires once
    always_ff @(posedge mclk) begin
        if (!rst_n || sclSync) begin
            sclLowCnt <= '0;
        end else if (sclLowCnt != SCL_LOW_CYC) begin
            sclLowCnt <= sclLowCnt + idf_pkg::CNT_ONE;
        end
    end
    assign sclLowHit = ~sclSync & (sclLowCnt == SCL_LOW_CYC - idf_pkg::CNT_ONE);

    // Own extension is summed over one message and cleared between messages
    always_ff @(posedge mclk) begin
        if (!rst_n || !eng.msgActive) begin
            extAcc <= '0;
        end else if (extOn && extAcc <= extLimit) begin
            extAcc <= extAcc + idf_pkg::CNT_ONE;
        end
    end
    assign extOn    = en & eng.msgActive & eng.ownStretch;
    assign extLimit = eng.slaveMode ? SEXT_CYC : MEXT_CYC;
    assign extHit   = extOn & (extAcc == extLimit);
    assign evTout   = en & (sclLowHit | extHit);

    assign noStr   = en & eng.slaveMode & ctrl[idf_pkg::C_NOSTR];
    assign rxData  = eng.rxDone & ~eng.rxIsAddr & ~eng.arbLostAck;
    // unread byte blocks the new one
    assign evOver  = noStr & rxData & rxUnread & ~dataRead;
    // no fresh byte when one is due
    assign evUnder = noStr & eng.txDue & eng.transmitting & ~txPending;
    assign store   = en & rxData & ~evOver;

    assign ev[idf_pkg::I_ALERT] = en & (host ? (alertPrev & ~alertSync) : eng.alertRespAddr);
    assign ev[idf_pkg::I_TOUT]  = evTout;
    assign ev[idf_pkg::I_PEC]   = en & eng.pecMismatch;
    assign ev[idf_pkg::I_OVR]   = evOver | evUnder;

    // ------------------------------------------------------------
    // Control and data buffer
    // ------------------------------------------------------------
    // Control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= idf_pkg::CTRL_RST;
        end else if (wr && hitCtrl) begin
            ctrl <= pwdata[idf_pkg::CTRL_W-1:0];
        end
    end

    // Received byte wins over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dataByte <= idf_pkg::DATA_RST;
        end else if (store) begin
            dataByte <= eng.rxByte;
        end else if (wrData) begin
            dataByte <= pwdata[idf_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !en) begin
            txPending   <= 1'b0;
            txEmptyFlag <= 1'b0;
        end else if (wrData) begin
            txPending   <= 1'b1;
            txEmptyFlag <= 1'b0;
        end else if (eng.txDue && eng.transmitting) begin
            txPending   <= 1'b0;
            txEmptyFlag <= 1'b1;
        end
    end

    // Unread marker; a new byte wins over the read that clears it
    always_ff @(posedge mclk) begin
        if (!rst_n || !en) begin
            rxUnread <= 1'b0;
        end else if (store) begin
            rxUnread <= 1'b1;
        end else if (dataRead) begin
            rxUnread <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Error flags and interrupt
    // ------------------------------------------------------------
    for (genvar i = 0; i < idf_pkg::IRQ_W; i++) begin : g_flag
        // zero clears, one keeps, set wins
        always_ff @(posedge mclk) begin
            if (!rst_n || !en) begin
                errFlag[i] <= 1'b0;
            end else if (ev[i]) begin
                errFlag[i] <= 1'b1;
            end else if (wrStat && !pwdata[idf_pkg::ERR_POS[i]]) begin
                errFlag[i] <= 1'b0;
            end
        end
        // Interrupt copy is write-one-to-clear and outlives a disable
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                irqSts[i] <= idf_pkg::IRQ_RST[i];
            end else if (ev[i]) begin
                irqSts[i] <= 1'b1;
            end else if (wr && hitIsts && pwdata[i]) begin
                irqSts[i] <= 1'b0;
            end
        end
    end

    // Mask register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irqMask <= idf_pkg::IRQ_RST;
        end else if (wr && hitImsk) begin
            irqMask <= pwdata[idf_pkg::IRQ_W-1:0];
        end
    end

    // Level output, one cycle behind the status bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqSts & irqMask);
        end
    end

    // ------------------------------------------------------------
    // Engine commands
    // ------------------------------------------------------------
    // Registered so the engine sees clean one-cycle pulses
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmd <= '0;
        end else begin
            // resent byte is the unchanged buffer
            cmd.txByte    <= dataByte;
            cmd.forceNack <= en & eng.pecMismatch;
            cmd.genStop   <= evTout & ~eng.slaveMode;
            cmd.resetComm <= evTout & eng.slaveMode;
        end
    end

    // ------------------------------------------------------------
    // Read path and APB answer
    // ------------------------------------------------------------
    // status layout, reserved bits zero
    always_comb begin
        statusWord = '0;
        for (int k = 0; k < idf_pkg::IRQ_W; k++) begin
            statusWord[idf_pkg::ERR_POS[k]] = errFlag[k];
        end
        statusWord[idf_pkg::B_TXE] = txEmptyFlag;
    end

    always_comb begin
        rdWord = '0;
        if (hitCtrl) rdWord[idf_pkg::CTRL_W-1:0] = ctrl;
        if (hitData) rdWord[idf_pkg::DATA_W-1:0] = dataByte;
        if (hitStat) rdWord = statusWord;
        if (hitIsts) rdWord[idf_pkg::IRQ_W-1:0] = irqSts;
        if (hitImsk) rdWord[idf_pkg::IRQ_W-1:0] = irqMask;
    end

    // One wait state: data is captured on the same edge that raises pready
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= (psel & penable & ~pready) ? rdWord : '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_buf_upper_zero: assert property (pready && hitData && !pwrite |-> prdata[31:8] == '0)
        else $error("data upper byte not zero");
    a_addr_not_stored: assert property (eng.rxDone && eng.rxIsAddr && !wrData |=> $stable(dataByte))
        else $error("address byte stored");
    a_write_overwrite: assert property (wrData && !store |=> dataByte == $past(pwdata[7:0]))
        else $error("write did not overwrite buffer");
    a_arb_discard: assert property (eng.rxDone && eng.arbLostAck && !wrData |=> $stable(dataByte))
        else $error("byte kept after lost arbitration");
    a_flags_disable: assert property (!en |=> errFlag == '0)
        else $error("error flag set while disabled");
    a_stat_layout: assert property (pready && hitStat && !pwrite |->
        prdata[15] == $past(errFlag[0]) && prdata[14] == $past(errFlag[1]) && !prdata[13])
        else $error("status layout wrong");
    a_alert_host: assert property (en && host && alertPrev && !alertSync |=> errFlag[0] && irqSts[0])
        else $error("alert not flagged");
    a_scl_timeout: assert property (en && sclLowHit |=> errFlag[1] && sclLowCnt == SCL_LOW_CYC)
        else $error("scl low timeout missed");
    a_mext_limit: assert property (extHit && en && !eng.slaveMode |=> errFlag[1] && extAcc > MEXT_CYC)
        else $error("master extension timeout missed");
    a_sext_limit: assert property (extHit && en && eng.slaveMode |=> errFlag[1] && extAcc > SEXT_CYC)
        else $error("slave extension timeout missed");
    a_slave_reset: assert property (evTout && eng.slaveMode |=> cmd.resetComm && !cmd.genStop)
        else $error("slave timeout did not reset");
    a_master_stop: assert property (evTout && !eng.slaveMode |=> cmd.genStop && !cmd.resetComm)
        else $error("master timeout without stop");
    a_pec_nack: assert property (en && eng.pecMismatch |=> cmd.forceNack && errFlag[2])
        else $error("pec mismatch not answered");
    a_ovr_gate: assert property ($rose(errFlag[3]) |-> $past(noStr))
        else $error("overrun outside slave no-stretch");
    a_ovr_drop: assert property (evOver && !wrData |=> $stable(dataByte) && errFlag[3])
        else $error("overrun byte not dropped");
    a_under_resend: assert property (evUnder |=> errFlag[3] ##1 cmd.txByte == $past(dataByte, 2))
        else $error("underrun did not resend");
    a_tx_empty: assert property (wrData && en |=> !txEmptyFlag && txPending)
        else $error("empty flag after write");
    a_w1_keep: assert property (wrStat && pwdata[12] && errFlag[2] && en |=> errFlag[2])
        else $error("write one cleared flag");

    // Read data is what the register held when the answer was built
    a_buf_readback: assert property (
        pready && hitData && !pwrite |-> prdata[idf_pkg::DATA_W-1:0] == $past(dataByte))
        else $error("buffer read back wrong");
    a_stat_low_bits: assert property (
        pready && hitStat && !pwrite |-> prdata[idf_pkg::B_PEC] == $past(errFlag[idf_pkg::I_PEC])
        && prdata[idf_pkg::B_OVR] == $past(errFlag[idf_pkg::I_OVR]))
        else $error("status low error bits wrong");
    // Address and lost bytes must not look like fresh data to software
    a_addr_no_unread: assert property (
        en && eng.rxDone && eng.rxIsAddr && !dataRead |=> $stable(rxUnread))
        else $error("address byte marked unread");
    a_arb_no_unread: assert property (
        en && eng.rxDone && eng.arbLostAck && !dataRead |=> $stable(rxUnread))
        else $error("lost byte marked unread");
    // A write lands even while the previous byte still waits
    a_write_when_full: assert property (
        wrData && !store && !txEmptyFlag |=> dataByte == $past(pwdata[idf_pkg::DATA_W-1:0]))
        else $error("write refused while not empty");
    // Zero clears, one keeps, read-only bits ignore the write
    a_zero_clear: assert property (
        wrStat && !pwdata[idf_pkg::B_TOUT] && !ev[idf_pkg::I_TOUT] |=> !errFlag[idf_pkg::I_TOUT])
        else $error("zero write kept timeout flag");
    a_ro_ignore: assert property (
        wrStat && !(eng.txDue && eng.transmitting) |=> $stable(txEmptyFlag))
        else $error("status write moved empty flag");
    // Slave alert comes from the response address only
    a_alert_slave: assert property (en && !host && eng.alertRespAddr |=> errFlag[idf_pkg::I_ALERT])
        else $error("alert response not flagged");

    // Counters restart, so only unbroken or per-message time counts
    a_scl_cnt_clear: assert property (sclSync |=> sclLowCnt == '0)
        else $error("scl low count not cleared");
    a_ext_msg_clear: assert property (!eng.msgActive |=> extAcc == '0)
        else $error("extension sum not cleared");
    // Commands only follow their own cause, never a stale one
    a_reset_cause: assert property (cmd.resetComm |-> $past(evTout) && $past(eng.slaveMode))
        else $error("reset without slave timeout");
    a_stop_cause: assert property (cmd.genStop |-> $past(evTout) && !$past(eng.slaveMode))
        else $error("stop without master timeout");
    a_nack_ack_off: assert property (en && eng.pecMismatch && !ctrl[idf_pkg::C_ACK] |=> cmd.forceNack)
        else $error("refusal depends on ack enable");

    // Overrun needs the no-stretch slave; a dropped byte leaves the old one unread
    a_no_ovr_stretch: assert property (!noStr |-> !ev[idf_pkg::I_OVR])
        else $error("overrun event with stretching");
    a_ovr_unread: assert property (evOver |=> rxUnread)
        else $error("dropped byte cleared unread");
    a_under_empty: assert property (evUnder |-> !txPending)
        else $error("underrun with a byte waiting");
    // Engine taking the byte empties the buffer
    a_tx_taken: assert property (
        en && !wrData && eng.txDue && eng.transmitting |=> txEmptyFlag && !txPending)
        else $error("empty flag not set after take");

endmodule : idf_data_flags

// File: sim/idf_engine_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side bus engine and the two pulled-up lines
// ------------------------------------------------------------
module idf_engine_model (
    input  wire logic         mclk,      // Block clock
    output idf_pkg::idf_eng_s eng,       // Engine events
    output logic              sclIn,     // SCL level, pulled up
    output logic              alert_flag_n // Alert pin, pulled up
);
    // Lines rest at their pull-up level
    initial begin
        eng = '0;
        sclIn = 1'b1;
        alert_flag_n = 1'b1;
    end
    // Mode levels only change between transfers
    task automatic mode(input logic sl, input logic tx);
        @(posedge mclk);
        eng.slaveMode <= sl;
        eng.transmitting <= tx;
    endtask : mode
    // One completed byte; address and lost-arbitration marks ride with it
    task automatic rx(input logic [7:0] b, input logic a, input logic l);
        @(posedge mclk);
        {eng.rxDone, eng.rxByte, eng.rxIsAddr, eng.arbLostAck} <= {1'b1, b, a, l};
        @(posedge mclk);
        eng.rxDone <= 1'b0;
    endtask : rx
    // Single-cycle event: 0 bad check code, 1 byte taken, 2 alert response
    task automatic pulse(input int k);
        @(posedge mclk);
        {eng.pecMismatch, eng.txDue, eng.alertRespAddr} <= 3'h4 >> k;
        @(posedge mclk);
        {eng.pecMismatch, eng.txDue, eng.alertRespAddr} <= 3'h0;
    endtask : pulse
    // SCL low for n cycles; st marks it as our own stretch inside a message
    task automatic low(input int n, input logic st);
        @(posedge mclk);
        {sclIn, eng.msgActive, eng.ownStretch} <= {1'b0, st, st};
        repeat (n) @(posedge mclk);
        {sclIn, eng.msgActive, eng.ownStretch} <= 3'h4;
        repeat (4) @(posedge mclk);
    endtask : low
    // Alert pin pulled low long enough to pass the synchroniser
    task automatic alert();
        @(posedge mclk);
        alert_flag_n <= 1'b0;
        repeat (6) @(posedge mclk);
        alert_flag_n <= 1'b1;
    endtask : alert
endmodule : idf_engine_model

// File: sim/i2c_data_and_error_flags_bench.sv
`timescale 1ns/100ps
module i2c_data_and_error_flags_bench;
    localparam int LL = 40, LM = 20, LS = 30;
    logic              mclk = 1'b0, rst_n, psel, penable, pwrite;
    logic [7:0]        paddr, b, c;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, irq, sclIn, alert_flag_n;
    idf_pkg::idf_eng_s eng;
    idf_pkg::idf_cmd_s cmd;
    logic [32:0]       expQ[$];
    int                bad_count = 0, checks = 0, seed = 48281, nStop = 0, nRst = 0, nNack = 0;
    logic [4:0]        ex = 5'h1A;
    int                nT[5] = '{LM - 1, LM + 2, LS - 1, LS + 2, LL + 10};

    always #2 mclk = ~mclk;

    // Short limits keep the timeout runs to a few dozen cycles
    idf_data_flags #(.SCL_LOW_CYC(23'h000028), .MEXT_CYC(23'h000014), .SEXT_CYC(23'h00001E)) DUT (
        .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .eng, .cmd, .sclIn, .alert_flag_n, .irq);
    idf_engine_model PM (.mclk, .eng, .sclIn, .alert_flag_n);

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Request held until pready is seen high; no cycle count assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        if (!w) expQ.push_back(e);
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && n++ < 60);
        // A slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            bad_count++;
            close_out();
        end
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    // Read answers meet the oldest note; command pulses are tallied
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, expQ.pop_front());
        nStop += cmd.genStop;
        nRst += cmd.resetComm;
        nNack += cmd.forceNack;
    end

    // Main sequence, control values: 1 enable, 2 host, 4 ack, 8 no stretch
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        b = 8'($random(seed));
        // Odd mask keeps the two bytes apart so a kept byte is told from a new one
        c = b ^ (8'($random(seed)) | 8'h01);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        apb(1'b0, 8'h30, 32'h0, 33'h100000000);
        wr(8'h00, 32'h9);
        wr(8'h10, {24'hFFFFFF, b});
        rd(8'h10, {24'h0, b});
        wr(8'h10, {24'h0, c});
        rd(8'h10, {24'h0, c});
        PM.mode(1'b1, 1'b0);
        PM.rx(b, 1'b1, 1'b0);
        rd(8'h10, {24'h0, c});
        PM.rx(b, 1'b0, 1'b1);
        rd(8'h10, {24'h0, c});
        PM.rx(b, 1'b0, 1'b0);
        PM.rx(~b, 1'b0, 1'b0);
        rd(8'h14, 32'h800);
        rd(8'h10, {24'h0, b});
        wr(8'h14, 32'hFFFF);
        rd(8'h14, 32'h800);
        wr(8'h14, 32'h0);
        wr(8'h00, 32'h1);
        PM.rx(b, 1'b0, 1'b0);
        PM.rx(c, 1'b0, 1'b0);
        rd(8'h14, 32'h0);
        rd(8'h10, {24'h0, c});
        wr(8'h00, 32'h9);
        PM.mode(1'b1, 1'b1);
        wr(8'h10, {24'h0, b});
        PM.pulse(1);
        PM.pulse(1);
        chk({25'h0, cmd.txByte}, {25'h0, b});
        rd(8'h14, 32'h880);
        wr(8'h14, 32'h0);
        rd(8'h14, 32'h80);
        wr(8'h10, {24'h0, c});
        rd(8'h14, 32'h0);
        // Check code failure must force the refusal with ack enable off and on
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, 32'h9 | (k << 2));
            PM.pulse(0);
            rd(8'h14, 32'h1000);
            wr(8'h14, 32'h0);
        end
        chk(33'(nNack), 33'h2);
        wr(8'h00, 32'hB);
        PM.alert();
        rd(8'h14, 32'h8000);
        wr(8'h14, 32'h0);
        wr(8'h00, 32'h9);
        PM.pulse(2);
        rd(8'h14, 32'h8000);
        wr(8'h14, 32'h0);
        // Extension just under and just over each limit, then a long SCL low
        for (int k = 0; k < 5; k++) begin
            PM.mode(k == 2 || k == 3, 1'b0);
            PM.low(nT[k], k < 4);
            rd(8'h14, ex[k] ? 32'h4000 : 32'h0);
            wr(8'h14, 32'h0);
        end
        chk(33'(nStop), 33'h2);
        chk(33'(nRst), 33'h1);
        PM.pulse(0);
        wr(8'h14, 32'hFFFF);
        rd(8'h14, 32'h1000);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h9);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'hF);
        chk({32'h0, irq}, 33'h0);
        wr(8'h24, 32'h4);
        repeat (3) @(posedge mclk);
        chk({32'h0, irq}, 33'h1);
        wr(8'h20, 32'h4);
        repeat (3) @(posedge mclk);
        chk({32'h0, irq}, 33'h0);
        rd(8'h20, 32'hB);
        @(posedge mclk);
        close_out();
    end

    // Whole run is well under this span; a hang counts as a mismatch
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
endmodule : i2c_data_and_error_flags_bench
